// ===== verilog/wave_seq_defines.svh
// register offsets, field positions, reset values and timing for the waveform sequencer slots
// assumes: included by the sequencer module and the bench only
`ifndef WAVE_SEQ_DEFINES_SVH
`define WAVE_SEQ_DEFINES_SVH

// register indices; byte address is four times the index
`define SEQ_CTRL_IDX      8'h0c
`define SEQ_SLOT8_IDX     8'h16
`define SEQ_REPEAT_IDX    8'h17
`define SEQ_STATUS_IDX    8'h1a

// field positions and slot count
`define SEQ_GO_BIT        0
`define SEQ_DELAY_BIT     7
`define SEQ_SLOTS         8

// reset values
`define SEQ_CTRL_RST      8'h00
`define SEQ_SLOT8_RST     8'h00
`define SEQ_REPEAT_RST    8'h00

// delay unit and clock rate
`define SEQ_DELAY_UNIT_MS 10
`define SEQ_CLK_HZ        25000000

`endif

// ===== verilog/wave_seq_pkg.sv
// types shared by the waveform sequencer and its surroundings
// assumes: compiled before any module that imports it
package wave_seq_pkg;

    // one sequence slot: delay select plus 7-bit value
    typedef struct packed {
        logic       delaySel;
        logic [6:0] value;
    } slot_t;

    // request to the waveform library
    typedef struct packed {
        logic       start;
        logic [6:0] id;
    } effect_req_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CHECK = 2'b01,
        ST_PLAY  = 2'b10,
        ST_DELAY = 2'b11
    } seq_state_t;

endpackage : wave_seq_pkg

// ===== verilog/waveform_sequencer_slots.sv
// sequencer slot eight, repeat counts of slots one to four, and the slot walk itself
// assumes: an AHB-Lite master on clk_sys, a waveform library answering on clk_sys,
// slots one to seven and repeat counts five to eight held by the rest of the engine
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/10ps
`include "wave_seq_defines.svh"

module waveform_sequencer_slots #(
    parameter int unsigned TICK_CYCLES = `SEQ_DELAY_UNIT_MS * (`SEQ_CLK_HZ / 1000)
) (
    input  wire logic                          clk_sys,
    input  wire logic                          reset,
    input  wire logic                          clkEn,
    // AHB-Lite slave
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic                               hreadyout,
    output logic                               hresp,
    output logic [31:0]                        hrdata,
    // rest of the engine
    input  wave_seq_pkg::slot_t [6:0]          slotsOneToSeven,
    input  wire logic [7:0]                    repeatHigh,
    output wave_seq_pkg::effect_req_t          effectReq,
    input  wire logic                          effectDone,
    output logic                               engineWaiting,
    output logic                               seqBusy
);
    import wave_seq_pkg::*;

    localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);

    // ---------------------------------------------------------------
    // registers and state
    // ---------------------------------------------------------------
    slot_t       slot8_q;
    logic [7:0]  repeat_q;
    logic        go_q;
    seq_state_t  state_q;
    logic [2:0]  slotIdx_q;
    logic [1:0]  repeatLeft_q;
    logic [6:0]  unitsLeft_q;
    logic [17:0] tickCnt_q;
    logic        addrValid_q;
    logic        addrWrite_q;
    logic [7:0]  addrIdx_q;
    logic        addrHigh_q;
    logic        readWait_q;

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    function automatic slot_t slotAt(input logic [2:0] idx, input slot_t s8,
                                     input slot_t [6:0] low);
        slotAt = (idx == 3'd7) ? s8 : low[idx];
    endfunction : slotAt

    function automatic logic [1:0] repeatOf(input logic [2:0] idx, input logic [7:0] lo,
                                            input logic [7:0] hi);
        logic [15:0] all;
        all      = {hi, lo};
        repeatOf = all[{idx, 1'b0} +: 2];
    endfunction : repeatOf

    slot_t      curSlot;
    logic       tickWrap;
    logic       stepDone;
    logic       lastSlot;
    logic [2:0] nextIdx;

    assign curSlot  = slotAt(slotIdx_q, slot8_q, slotsOneToSeven);
    assign tickWrap = (tickCnt_q == TICK_LAST);
    assign stepDone = clkEn && (((state_q == ST_PLAY) && effectDone)
                    || ((state_q == ST_DELAY) && tickWrap && (unitsLeft_q == 7'd1)));
    assign lastSlot = (slotIdx_q == 3'(`SEQ_SLOTS - 1));
    assign nextIdx  = slotIdx_q + 3'd1;

    // ---------------------------------------------------------------
    // AHB-Lite slave
    // ---------------------------------------------------------------
    logic addrPhase;
    logic wrStrobe;
    logic seqEnd;
    logic readPend;

    // reads add one wait state so read data always come from a flop:
    // the first data cycle of a read holds the bus while hrdata is loaded
    assign addrPhase = hsel && htrans[1] && hready;
    assign wrStrobe  = clkEn && addrValid_q && addrWrite_q && !addrHigh_q;
    assign readPend  = addrValid_q && !addrWrite_q && !readWait_q;
    assign hreadyout = !readPend;
    assign hresp     = 1'b0;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            addrValid_q <= 1'b0;
            addrWrite_q <= 1'b0;
            addrIdx_q   <= 8'h00;
            addrHigh_q  <= 1'b0;
        end
        else if (clkEn && hready)
        begin
            addrValid_q <= addrPhase;
            addrWrite_q <= hwrite;
            addrIdx_q   <= haddr[9:2];
            addrHigh_q  <= (haddr[31:10] != 22'h000000) || (haddr[1:0] != 2'b00);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            readWait_q <= 1'b0;
        else if (clkEn)
            readWait_q <= readPend;
    end

    // unmapped or misaligned addresses read as zero
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            hrdata <= 32'h00000000;
        else if (clkEn && readPend)
        begin
            hrdata <= 32'h00000000;
            if (!addrHigh_q)
            begin
                case (addrIdx_q)
                    `SEQ_CTRL_IDX:   hrdata <= {31'h00000000, go_q};
                    `SEQ_SLOT8_IDX:  hrdata <= {24'h000000, slot8_q};
                    `SEQ_REPEAT_IDX: hrdata <= {24'h000000, repeat_q};
                    `SEQ_STATUS_IDX: hrdata <= {24'h000000, seqBusy, state_q,
                                                repeatLeft_q, slotIdx_q};
                    default:         hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // software registers
    // ---------------------------------------------------------------
    // reset and write
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            slot8_q  <= slot_t'(`SEQ_SLOT8_RST);
            repeat_q <= `SEQ_REPEAT_RST;
        end
        else if (wrStrobe && (addrIdx_q == `SEQ_SLOT8_IDX))
            slot8_q <= slot_t'(hwdata[7:0]);
        else if (wrStrobe && (addrIdx_q == `SEQ_REPEAT_IDX))
            repeat_q <= hwdata[7:0];
    end

    // go clears itself at the end; a software set in that cycle wins
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            go_q <= 1'(`SEQ_CTRL_RST);
        else if (wrStrobe && (addrIdx_q == `SEQ_CTRL_IDX))
            go_q <= hwdata[`SEQ_GO_BIT];
        else if (seqEnd)
            go_q <= 1'b0;
    end

    // ---------------------------------------------------------------
    // slot walk
    // ---------------------------------------------------------------
    assign seqEnd = clkEn && (state_q != ST_IDLE) && (
                    ((state_q == ST_CHECK) && (curSlot.value == 7'h00))
                 || (stepDone && (repeatLeft_q == 2'd0) && lastSlot));

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state_q      <= ST_IDLE;
            slotIdx_q    <= 3'd0;
            repeatLeft_q <= 2'd0;
            unitsLeft_q  <= 7'h00;
            effectReq    <= '0;
        end
        else if (clkEn)
        begin
            effectReq.start <= 1'b0;
            // writing go low aborts a running sequence
            if (!go_q && (state_q != ST_IDLE))
                state_q <= ST_IDLE;
            else
            begin
                case (state_q)
                    ST_IDLE:
                    begin
                        if (go_q)
                        begin
                            state_q      <= ST_CHECK;
                            slotIdx_q    <= 3'd0;
                            repeatLeft_q <= repeatOf(3'd0, repeat_q, repeatHigh);
                        end
                    end
                    ST_CHECK:
                    begin
                        if (curSlot.value == 7'h00)
                            state_q <= ST_IDLE;
                        else if (curSlot.delaySel)
                        begin
                            state_q     <= ST_DELAY;
                            unitsLeft_q <= curSlot.value;
                        end
                        else
                        begin
                            state_q      <= ST_PLAY;
                            effectReq.id <= curSlot.value;
                            effectReq.start <= 1'b1;
                        end
                    end
                    ST_DELAY:
                    begin
                        if (tickWrap)
                            unitsLeft_q <= unitsLeft_q - 7'd1;
                    end
                    default:
                    begin
                    end
                endcase
                if (stepDone)
                begin
                    state_q <= ST_CHECK;
                    if (repeatLeft_q != 2'd0)
                        repeatLeft_q <= repeatLeft_q - 2'd1;
                    else if (lastSlot)
                        state_q <= ST_IDLE;
                    else
                    begin
                        slotIdx_q    <= nextIdx;
                        repeatLeft_q <= repeatOf(nextIdx, repeat_q, repeatHigh);
                    end
                end
            end
        end
    end

    // tick prescaler for the 10 ms unit
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            tickCnt_q <= 18'h00000;
        else if (clkEn)
            tickCnt_q <= ((state_q != ST_DELAY) || tickWrap) ? 18'h00000 : tickCnt_q + 18'h00001;
    end

    assign engineWaiting = (state_q == ST_DELAY);
    assign seqBusy       = (state_q != ST_IDLE);

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    chk_delay_no_effect: assert property (
        (state_q == ST_DELAY) |-> !effectReq.start)
        else $error("effect started during delay slot");

    chk_delay_load: assert property (
        (clkEn && go_q && state_q == ST_CHECK && curSlot.delaySel && curSlot.value != 7'h00)
        |=> (state_q == ST_DELAY) && (unitsLeft_q == $past(curSlot.value)))
        else $error("delay units not loaded from slot value");

    chk_delay_tick: assert property (
        (clkEn && go_q && state_q == ST_DELAY && tickWrap && unitsLeft_q > 7'd1)
        |=> unitsLeft_q == $past(unitsLeft_q) - 7'd1)
        else $error("delay unit not counted at tick wrap");

    chk_effect_index: assert property (
        (clkEn && go_q && state_q == ST_CHECK && !curSlot.delaySel && curSlot.value != 7'h00)
        |=> effectReq.start && (effectReq.id == $past(curSlot.value)) ##1 !effectReq.start)
        else $error("library index or start pulse wrong");

    chk_go_start: assert property (
        (clkEn && go_q && state_q == ST_IDLE) |=> (state_q == ST_CHECK) && (slotIdx_q == 3'd0))
        else $error("go did not start at slot one");

    chk_slot_advance: assert property (
        (stepDone && go_q && repeatLeft_q == 2'd0 && !lastSlot)
        |=> (slotIdx_q == $past(slotIdx_q) + 3'd1) && (state_q == ST_CHECK))
        else $error("sequencer did not advance one slot");

    chk_last_stop: assert property (
        (stepDone && go_q && repeatLeft_q == 2'd0 && lastSlot) |=> (state_q == ST_IDLE) && !go_q)
        else $error("sequence ran past slot eight");

    chk_zero_stop: assert property (
        (clkEn && go_q && state_q == ST_CHECK && curSlot.value == 7'h00)
        |=> (state_q == ST_IDLE) && !effectReq.start)
        else $error("zero identifier did not stop sequence");

    chk_repeat_replay: assert property (
        (stepDone && go_q && repeatLeft_q != 2'd0)
        |=> $stable(slotIdx_q) && (repeatLeft_q == $past(repeatLeft_q) - 2'd1))
        else $error("repeat did not replay same slot");

    chk_repeat_field: assert property (
        (stepDone && go_q && repeatLeft_q == 2'd0 && !lastSlot && nextIdx < 3'd4)
        |=> repeatLeft_q == repeat_q[{slotIdx_q[1:0], 1'b0} +: 2])
        else $error("repeat count taken from wrong field");

    chk_reset_regs: assert property (@(posedge clk_sys) disable iff (1'b0)
        reset |=> (slot8_q == slot_t'(8'h00)) && (repeat_q == 8'h00))
        else $error("slot or repeat register not zero after reset");

    cov_delay_slot: cover property (state_q == ST_DELAY ##1 state_q == ST_CHECK);
    cov_full_walk:  cover property (stepDone && lastSlot && repeatLeft_q == 2'd0);
    cov_replay:     cover property (stepDone && repeatLeft_q == 2'd3);
    cov_zero_end:   cover property (state_q == ST_CHECK && curSlot.value == 7'h00 && go_q);

endmodule : waveform_sequencer_slots

// ===== testbench/effect_library_model.sv
// waveform library stand-in: answers each effect start with a one-cycle done pulse
// assumes: same clock as the sequencer; latency is set by the bench for each play
`timescale 1ns/10ps

module effect_library_model (
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    input  wave_seq_pkg::effect_req_t effectReq,
    input  wire logic [3:0]           latency,
    output logic                      effectDone,
    output logic [7:0]                playCount,
    output logic [6:0]                lastId
);
    import wave_seq_pkg::*;

    logic [3:0] waitLeft;
    logic       running;

    // ----------------------------------------
    // effect playback
    // ----------------------------------------
    // latency 0 answers as fast as a real library can; larger values stall the walk
    always_ff @(posedge clk_sys)
    begin
        effectDone <= 1'b0;
        if (reset)
        begin
            running   <= 1'b0;
            playCount <= 8'h00;
            lastId    <= 7'h00;
            waitLeft  <= 4'h0;
        end
        else if (effectReq.start)
        begin
            running   <= 1'b1;
            waitLeft  <= latency;
            playCount <= playCount + 8'h01;
            lastId    <= effectReq.id;
        end
        else if (running)
        begin
            if (waitLeft == 4'h0)
            begin
                effectDone <= 1'b1;
                running    <= 1'b0;
            end
            else
                waitLeft <= waitLeft - 4'h1;
        end
    end
endmodule : effect_library_model

// ===== testbench/tb_top.sv
// self-checking bench for the sequencer slots: AHB-Lite register access and slot walk
// assumes: one 25 MHz clock, library model on the effect interface, short delay tick
`timescale 1ns/10ps
`include "wave_seq_defines.svh"

module tb_top;
    import wave_seq_pkg::*;

    localparam int          TICK       = 4;
    localparam logic [31:0] ADDR_CTRL  = {22'h0, `SEQ_CTRL_IDX, 2'b00};
    localparam logic [31:0] ADDR_SLOT8 = {22'h0, `SEQ_SLOT8_IDX, 2'b00};
    localparam logic [31:0] ADDR_REP   = {22'h0, `SEQ_REPEAT_IDX, 2'b00};

    logic              clk_sys = 1'b0;
    logic              reset   = 1'b1;
    logic              hsel    = 1'b0;
    logic [31:0]       haddr   = 32'h0;
    logic [1:0]        htrans  = 2'b00;
    logic              hwrite  = 1'b0;
    logic [31:0]       hwdata  = 32'h0;
    logic              hready, hresp, effectDone, engineWaiting, seqBusy;
    logic [31:0]       hrdata, rd;
    slot_t [6:0]       slotsLow;
    logic [7:0]        repeatHigh = 8'h00;
    logic [3:0]        libLatency = 4'h0;
    effect_req_t       effectReq;
    logic [7:0]        playCount, base;
    logic [6:0]        lastId;
    int                errTotal = 0, numChecks = 0, waitCnt;

    always #20 clk_sys = ~clk_sys;

    waveform_sequencer_slots #(.TICK_CYCLES(TICK)) waveform_sequencer_slots_inst (
        .clk_sys(clk_sys), .reset(reset), .clkEn(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .slotsOneToSeven(slotsLow),
        .repeatHigh(repeatHigh), .effectReq(effectReq), .effectDone(effectDone),
        .engineWaiting(engineWaiting), .seqBusy(seqBusy));

    effect_library_model effect_library_model_inst (
        .clk_sys(clk_sys), .reset(reset), .effectReq(effectReq), .latency(libLatency),
        .effectDone(effectDone), .playCount(playCount), .lastId(lastId));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        numChecks++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("[FAIL] %0t %s: got %h want %h", $time, msg, seen, exp);
        end
    endtask : check

    // address phase held until hready, then data phase held until hready again
    task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= wr;
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0, "response not okay");
    endtask : ahb_xfer

    // loads slot eight and the repeat counts, starts playback, waits for the walk to end
    task automatic play(input logic [7:0] s8, input logic [7:0] rep, input logic [3:0] lat);
        ahb_xfer(1'b1, ADDR_SLOT8, {24'h0, s8});
        ahb_xfer(1'b1, ADDR_REP, {24'h0, rep});
        libLatency <= lat;
        base = playCount;
        waitCnt = 0;
        ahb_xfer(1'b1, ADDR_CTRL, 32'h1);
        repeat (2) @(posedge clk_sys);
        while (seqBusy === 1'b1)
        begin
            if (engineWaiting === 1'b1)
                waitCnt++;
            @(posedge clk_sys);
        end
        repeat (3) @(posedge clk_sys);
    endtask : play

    task automatic testDone;
        $display("checks %0d mismatches %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : testDone

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_regs;
        ahb_xfer(1'b0, ADDR_SLOT8, 32'h0); check(rd, 32'h0, "slot8 reset");
        ahb_xfer(1'b0, ADDR_REP, 32'h0);   check(rd, 32'h0, "repeat reset");
        ahb_xfer(1'b1, ADDR_SLOT8, 32'ha5);
        ahb_xfer(1'b1, ADDR_REP, 32'h5a);
        ahb_xfer(1'b0, ADDR_SLOT8, 32'h0); check(rd, 32'ha5, "slot8 rw");
        ahb_xfer(1'b0, ADDR_REP, 32'h0);   check(rd, 32'h5a, "repeat rw");
        ahb_xfer(1'b0, 32'h3fc, 32'h0);    check(rd, 32'h0, "unmapped read");
        $display("test_regs done");
    endtask : test_regs

    task automatic test_stop;
        slotsLow[0] <= '0;
        play(8'h11, 8'h00, 4'h0);
        check(32'(playCount - base), 32'd0, "zero first slot played");
        ahb_xfer(1'b0, ADDR_CTRL, 32'h0);  check(rd, 32'h0, "go not cleared");
        slotsLow[0] <= '{1'b0, 7'h21};
        slotsLow[1] <= '0;
        play(8'h11, 8'h00, 4'h2);
        check(32'(playCount - base), 32'd1, "stop after one");
        check(32'(lastId), 32'h21, "first slot effect id");
        $display("test_stop done");
    endtask : test_stop

    task automatic test_repeat;
        for (int i = 0; i < 7; i++)
            slotsLow[i] <= '{1'b0, 7'(i + 1)};
        slotsLow[4] <= '0;
        // slot four 3, slot three 2, slot two 1, slot one 0: 4+3+2+1 plays
        play(8'h11, 8'he4, 4'h5);
        check(32'(playCount - base), 32'd10, "repeat plays");
        check(32'(lastId), 32'h04, "repeat last id");
        play(8'h11, 8'h03, 4'h0);
        check(32'(playCount - base), 32'd7, "slot one repeat");
        $display("test_repeat done");
    endtask : test_repeat

    task automatic test_eight;
        slotsLow[4] <= '{1'b0, 7'h05};
        play(8'h55, 8'h00, 4'h0);
        check(32'(playCount - base), 32'd8, "eight slot plays");
        check(32'(lastId), 32'h55, "slot8 effect id");
        check(32'(waitCnt), 32'd0, "no wait for effect");
        play(8'h83, 8'h00, 4'h1);
        check(32'(playCount - base), 32'd7, "delay slot played");
        check(32'(lastId), 32'h07, "last effect before delay");
        check(32'(waitCnt), 32'(3 * TICK), "delay length");
        $display("test_eight done");
    endtask : test_eight

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        for (int i = 0; i < 7; i++)
            slotsLow[i] = '{1'b0, 7'(i + 1)};
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        test_regs;
        test_stop;
        test_repeat;
        test_eight;
        testDone;
    end

    // whole run needs a few hundred cycles; this margin only catches a hang
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        errTotal++;
        $display("[FAIL] %0t watchdog expired", $time);
        testDone;
    end
endmodule : tb_top
